// ### core/rst_seq_pkg.sv
// Package of constants and carrier types for the reset and strap sequencer
`default_nettype none
package rst_seq_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SHORT_DELAY_US = 100;
  localparam int unsigned LONG_DELAY_MS  = 20;
  localparam int unsigned SHORT_CYCLES   = (SHORT_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LONG_CYCLES    = (LONG_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 22;
  localparam int unsigned PROC_CYCLES    = 4;
  localparam logic [3:0]  PROC_W_CNT     = 4'h4;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned SHARED_N     = 4;
  localparam logic        BUS_WIDE_RST = 1'b1;
  localparam logic        MAJOR_RST    = 1'b1;

  // Pins that double as upper address or chip select, index 0 = address bit 27
  typedef struct packed {
    logic [SHARED_N-1:0] addr;
    logic [SHARED_N-1:0] sel_n;
    logic [SHARED_N-1:0] is_sel;
  } shared_req_s;

  typedef struct packed {
    logic [SHARED_N-1:0] out;
    logic [SHARED_N-1:0] oe;
  } shared_pin_s;
endpackage
`default_nettype wire

// ### core/delay_counter.sv
// Down counter that measures the reset extension delay
`default_nettype none
module delay_counter
  import rst_seq_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             done_reg;
  logic             done_next;

  // Load on request, then count to the terminal value of one
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (load_i) begin
      cnt_next = load_val_i;             // see [RULE12]
    end else if (cnt_reg > 22'h000001) begin
      cnt_next = cnt_reg - 22'h000001;
    end else if (cnt_reg == 22'h000001) begin
      cnt_next  = 22'h000000;
      done_next = 1'b1;                  // see [RULE12]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 22'h000000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;
endmodule
`default_nettype wire

// ### core/reset_strap_sequencer.sv
// Reset sequencer: strap sampling, reset extension, boot select and shared pins
`default_nettype none
// What this block does and what it needs from the board
// [RULE1] The board must hold the reset input low at least 100 us after the supplies settle.
// [RULE2] A configuration input picks major or minor reset processing after reset.
// [RULE3] The delay strap picks a 100 us extension when low and 20 ms when high.
// [RULE4] The delay strap is taken at the reset input's rising edge and lengthens both resets.
// [RULE5] After the delay, the chosen processing runs and the core is then let run.
// [RULE6] The width strap picks an 8-bit data bus when low and 16-bit when high.
// [RULE7] The reset output stays low for the whole selected delay.
// [RULE8] The four shared address or chip select pins float while reset is active.
// [RULE9] After reset each shared pin carries address bit 27 to 30 or chip select 7 to 4.
// [RULE10] Boot chip select zero is driven low at reset for booting from address zero.
// [RULE11] The delay strap pin also serves as address bit 25 and the width strap as bit 26.
// [RULE12] The delay is a counter on the core clock, loaded from the strap, done at terminal.
module reset_strap_sequencer
  import rst_seq_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                reset_in_n_i,
  input  wire logic                delay_strap_i,
  input  wire logic                width_strap_i,
  input  wire logic                major_sel_i,
  input  wire logic                addr25_i,
  input  wire logic                addr26_i,
  input  wire logic                addr_oe_i,
  input  wire logic                boot_sel_n_i,
  input  wire shared_req_s         shared_req_i,
  output logic                     reset_out_n_o,
  output logic                     core_run_o,
  output logic                     proc_busy_o,
  output logic                     proc_major_o,
  output logic                     bus_wide_o,
  output logic                     long_delay_o,
  output logic                     addr25_o,
  output logic                     addr25_oe_o,
  output logic                     addr26_o,
  output logic                     addr26_oe_o,
  output logic                     boot_select_low_o,
  output shared_pin_s              shared_pin_o
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_PROC, ST_RUN} seq_e;

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       rin_prev_reg;

  // Pins are asynchronous; only the second stage is looked at. The edge
  // detector clears to low on purpose: a reset input that is already high
  // when the core reset lifts counts as a release and starts a sequence,
  // so a board without a supervisor still comes out of reset.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg     <= 3'h0;
      sync_reg     <= 3'h0;
      rin_prev_reg <= 1'b0;
    end else begin
      meta_reg     <= {width_strap_i, delay_strap_i, reset_in_n_i};
      sync_reg     <= meta_reg;
      rin_prev_reg <= sync_reg[0];
    end
  end

  logic rin_n;
  logic rin_rise;
  assign rin_n    = sync_reg[0];
  assign rin_rise = rin_n & ~rin_prev_reg;

  // ----------------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------------
  seq_e       state_reg;
  seq_e       state_next;
  logic       long_reg;
  logic       long_next;
  logic       wide_reg;
  logic       wide_next;
  logic       major_reg;
  logic       major_next;
  logic [3:0] proc_cnt_reg;
  logic [3:0] proc_cnt_next;
  logic       load;
  logic [CNT_W-1:0] load_val;
  logic       delay_done;

  // The counter keeps running after an abort; the next release reloads it,
  // so a stale terminal pulse can only land while the sequencer holds.
  delay_counter u_delay (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (load),
    .load_val_i (load_val),
    .done_o     (delay_done)
  );

  // Straps are sampled at the release edge while the strap pins are still inputs
  always_comb begin
    state_next    = state_reg;
    long_next     = long_reg;
    wide_next     = wide_reg;
    major_next    = major_reg;
    proc_cnt_next = proc_cnt_reg;
    load          = 1'b0;
    load_val      = sync_reg[1] ? CNT_W'(LONG_CYCLES) : CNT_W'(SHORT_CYCLES); // see [RULE3]
    case (state_reg)
      ST_HOLD: begin
        // Straps and the major bit are taken on the release edge only
        if (rin_rise) begin
          long_next  = sync_reg[1];      // see [RULE4]
          wide_next  = sync_reg[2];      // see [RULE6]
          major_next = major_sel_i;      // see [RULE2]
          load       = 1'b1;             // see [RULE12]
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (delay_done) begin
          proc_cnt_next = PROC_W_CNT;
          state_next    = ST_PROC;       // see [RULE5]
        end
      end
      ST_PROC: begin
        // Same length for major and minor processing; the choice is only reported
        if (proc_cnt_reg == 4'h1) begin
          state_next = ST_RUN;           // see [RULE5]
        end
        proc_cnt_next = proc_cnt_reg - 4'h1;
      end
      ST_RUN: begin
      end
      default: state_next = ST_HOLD;
    endcase
    // A low reset input restarts the whole sequence from any state
    if (!rin_n) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_HOLD;
      long_reg     <= 1'b0;
      wide_reg     <= BUS_WIDE_RST;
      major_reg    <= MAJOR_RST;
      proc_cnt_reg <= 4'h0;
    end else begin
      state_reg    <= state_next;
      long_reg     <= long_next;
      wide_reg     <= wide_next;
      major_reg    <= major_next;
      proc_cnt_reg <= proc_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Registered pin drive
  // ----------------------------------------------------------------------
  logic        in_reset;
  logic        run_next;
  logic        busy_next;
  logic        boot_next;
  logic        strap_oe_next;
  shared_pin_s pin_next;

  // Shared pins float in reset so the board pulls set their level; once
  // running, a pin set up as select shows its select, else its address bit
  function automatic shared_pin_s shared_drive(input shared_req_s req,
                                               input logic        addr_oe,
                                               input logic        hold);
    shared_pin_s pin;
    pin.out = (req.is_sel & req.sel_n) | (~req.is_sel & req.addr);          // see [RULE9]
    pin.oe  = hold ? {SHARED_N{1'b0}} : ({SHARED_N{addr_oe}} | req.is_sel); // see [RULE8]
    return pin;
  endfunction

  // Every pin decision is made here from the next state, so the flops below
  // only register and each pin changes on the same edge as the state
  always_comb begin
    run_next      = (state_next == ST_RUN);          // see [RULE5]
    in_reset      = ~run_next;                       // see [RULE7]
    busy_next     = (state_next == ST_PROC);
    // Boot select is forced low until run so the first fetch reaches boot memory
    boot_next     = in_reset ? 1'b0 : boot_sel_n_i;  // see [RULE10]
    // Strap pins stay inputs until run; they become address bits 25 and 26 then
    strap_oe_next = addr_oe_i & run_next;            // see [RULE11]
    pin_next      = shared_drive(shared_req_i, addr_oe_i, in_reset);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reset_out_n_o     <= 1'b0;
      core_run_o        <= 1'b0;
      proc_busy_o       <= 1'b0;
      proc_major_o      <= MAJOR_RST;
      bus_wide_o        <= BUS_WIDE_RST;
      long_delay_o      <= 1'b0;
      addr25_o          <= 1'b0;
      addr25_oe_o       <= 1'b0;
      addr26_o          <= 1'b0;
      addr26_oe_o       <= 1'b0;
      boot_select_low_o <= 1'b0;
      shared_pin_o      <= '0;
    end else begin
      reset_out_n_o     <= ~in_reset;       // see [RULE7]
      core_run_o        <= run_next;        // see [RULE5]
      proc_busy_o       <= busy_next;
      proc_major_o      <= major_next;      // see [RULE2]
      bus_wide_o        <= wide_next;       // see [RULE6]
      long_delay_o      <= long_next;       // see [RULE4]
      addr25_o          <= addr25_i;        // see [RULE11]
      addr25_oe_o       <= strap_oe_next;   // see [RULE11]
      addr26_o          <= addr26_i;        // see [RULE11]
      addr26_oe_o       <= strap_oe_next;   // see [RULE11]
      boot_select_low_o <= boot_next;       // see [RULE10]
      shared_pin_o      <= pin_next;
    end
  end
endmodule
`default_nettype wire

// ### tb/rst_seq_asserts.sv
// Checker for the reset and strap sequencer
`default_nettype none
module rst_seq_asserts
  import rst_seq_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        reset_in_n_i,
  input wire logic        reset_out_n_o,
  input wire logic        core_run_o,
  input wire logic        proc_busy_o,
  input wire logic        long_delay_o,
  input wire logic        bus_wide_o,
  input wire logic        addr25_oe_o,
  input wire logic        boot_select_low_o,
  input wire shared_pin_s shared_pin_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Low time of the reset output
  // ----
  localparam int unsigned PIPE_CYCLES = 4; // Two sync stages, counter load, done flop
  logic [CNT_W-1:0] low_reg;
  logic [CNT_W-1:0] low_next;
  // Cycles with the reset input high and the reset output still low. Counting
  // from the input's release keeps the board's own low time from hiding a
  // short extension. Saturates so that it cannot wrap.
  always_comb begin
    low_next = low_reg + {{(CNT_W-1){1'b0}}, ~&low_reg};
    if (reset_out_n_o || !reset_in_n_i) begin
      low_next = '0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    low_reg <= rst_i ? '0 : low_next;
  end
  float_pins_a: assert property (!core_run_o |-> shared_pin_o.oe == '0)
    else $error("shared pins driven before run");
  strap_pins_a: assert property (!core_run_o |-> !addr25_oe_o)
    else $error("strap pin driven before run");
  boot_low_a: assert property (!core_run_o |-> !boot_select_low_o)
    else $error("boot select not low in reset");
  out_run_a: assert property (reset_out_n_o == core_run_o)
    else $error("reset output and run disagree");
  busy_len_a: assert property ($rose(proc_busy_o) |-> proc_busy_o[*4] ##1 core_run_o)
    else $error("processing length wrong");
  low_len_a: assert property ($rose(reset_out_n_o) |->
    low_reg >= (long_delay_o ? LONG_CYCLES : SHORT_CYCLES))
    else $error("reset output released early");
  late_len_a: assert property ($rose(reset_out_n_o) |->
    low_reg <= (long_delay_o ? LONG_CYCLES : SHORT_CYCLES) + PROC_CYCLES + PIPE_CYCLES)
    else $error("reset output released late");
  latch_hold_a: assert property (core_run_o ##1 core_run_o |->
    $stable(long_delay_o) && $stable(bus_wide_o))
    else $error("strap latch changed while running");
  abort_run_a: assert property (!reset_in_n_i[*5] |=> !core_run_o)
    else $error("run kept while reset input low");
endmodule
bind reset_strap_sequencer rst_seq_asserts u_chk (.core_clk_i, .rst_i, .reset_in_n_i,
  .reset_out_n_o, .core_run_o, .proc_busy_o, .long_delay_o, .bus_wide_o, .addr25_oe_o,
  .boot_select_low_o, .shared_pin_o);
`default_nettype wire

// ### tb/board_model.sv
// Board reset supervisor and strap pull resistors
`default_nettype none
module board_model (
  input  wire logic core_clk_i,
  input  wire logic go_i,
  input  wire logic dly_i,
  input  wire logic wid_i,
  output logic      reset_n_o,
  output logic      delay_strap_o,
  output logic      width_strap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Reset pulse
  // ----
  localparam int HOLD = 8;
  localparam int LOW = 10000;
  int cnt_reg = 0;
  // A new request restarts the pulse, so a running sequence is aborted
  always @(posedge core_clk_i) begin
    if (go_i) cnt_reg <= LOW + HOLD;
    else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
  end
  assign reset_n_o = (cnt_reg <= HOLD);
  // Straps held a few cycles past the rise, then the pull-ups win
  assign delay_strap_o = (cnt_reg == 0) ? 1'b1 : dly_i;
  assign width_strap_o = (cnt_reg == 0) ? 1'b1 : wid_i;
endmodule
`default_nettype wire

// ### tb/test_reset_strap_sequencer.sv
// Self-checking bench for the reset and strap sequencer
`default_nettype none
module test_reset_strap_sequencer
  import rst_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0, rst_i = 1'b1, major_sel_i = 1'b0, addr25_i = 1'b0, addr26_i = 1'b0;
  logic addr_oe_i = 1'b0, boot_sel_n_i = 1'b1, go = 1'b0, dly = 1'b0, wid = 1'b0;
  logic reset_in_n_i, delay_strap_i, width_strap_i, reset_out_n_o, core_run_o, proc_busy_o;
  logic proc_major_o, bus_wide_o, long_delay_o, addr25_o, addr25_oe_o, addr26_o, addr26_oe_o;
  logic boot_select_low_o;
  logic [31:0] r;
  shared_req_s shared_req_i = '0;
  shared_pin_s shared_pin_o;
  int n_errors = 0, n_compared = 0, n = 0, seed = 32'h7292c4fa;
  reset_strap_sequencer u_dut (.core_clk_i, .rst_i, .reset_in_n_i, .delay_strap_i,
    .width_strap_i, .major_sel_i, .addr25_i, .addr26_i, .addr_oe_i, .boot_sel_n_i,
    .shared_req_i, .reset_out_n_o, .core_run_o, .proc_busy_o, .proc_major_o, .bus_wide_o,
    .long_delay_o, .addr25_o, .addr25_oe_o, .addr26_o, .addr26_oe_o, .boot_select_low_o,
    .shared_pin_o);
  board_model u_board (.core_clk_i, .go_i(go), .dly_i(dly), .wid_i(wid),
    .reset_n_o(reset_in_n_i), .delay_strap_o(delay_strap_i), .width_strap_o(width_strap_i));
  always #5 core_clk_i = ~core_clk_i;
  // ----
  // Checking helpers
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Every polling loop waits through here, so a hang ends the run
  task automatic tick(input int lim);
    @(posedge core_clk_i);
    n++;
    if (n > lim) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // Shared pins: select where asked, address otherwise; drive when either wants it
  function automatic logic [7:0] pin_exp(input logic [31:0] v);
    return {(v[7:4] & v[3:0]) | (v[11:8] & ~v[3:0]), v[3:0] | {4{v[12]}}};
  endfunction
  task automatic pulse(input logic d, input logic w, input logic m);
    @(posedge core_clk_i);
    dly <= d;
    wid <= w;
    major_sel_i <= m;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    n = 0;
    tick(4);
    while (reset_in_n_i !== 1'b1) tick(20000);
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Long strap: still held in reset well past the short count
    pulse(1'b1, 1'b0, 1'b0);
    // Requests that would drive every pin, to show they are held off in reset
    shared_req_i <= 12'hfff;
    addr_oe_i    <= 1'b1;
    repeat (SHORT_CYCLES + 100) @(posedge core_clk_i);
    chk("long_delay", 8'h1, {7'h0, long_delay_o});
    chk("reset_out", 8'h0, {7'h0, reset_out_n_o});
    chk("float_pins", 8'h0, {4'h0, shared_pin_o.oe});
    chk("boot_reset", 8'h0, {7'h0, boot_select_low_o});
    chk("strap_oe", 8'h0, {6'h0, addr26_oe_o, addr25_oe_o});
    $display("long delay test done");
    // Each pulse aborts whatever runs; straps flip to pull-up after the rise
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      pulse(1'b0, r[16], i[0]);
      n = 0;
      while (core_run_o !== 1'b1) tick(SHORT_CYCLES + 12);
      chk("extension", 8'h1, {7'h0, n >= SHORT_CYCLES});
      chk("bus_wide", {7'h0, r[16]}, {7'h0, bus_wide_o});
      chk("major", {7'h0, i[0]}, {7'h0, proc_major_o});
      chk("long_delay", 8'h0, {7'h0, long_delay_o});
      chk("reset_out", 8'h1, {7'h0, reset_out_n_o});
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk_i);
        r = k ? $random(seed) : 32'h0000_10f0;
        shared_req_i <= r[11:0];
        addr_oe_i <= r[12];
        boot_sel_n_i <= r[13];
        addr25_i <= r[14];
        addr26_i <= r[15];
        // Looked at mid-cycle, once the registered pins have settled
        repeat (3) @(negedge core_clk_i);
        chk("shared_pins", pin_exp(r), shared_pin_o);
        chk("boot", {7'h0, r[13]}, {7'h0, boot_select_low_o});
        chk("addr25", {6'h0, r[12], r[14]}, {6'h0, addr25_oe_o, addr25_o});
        chk("addr26", {6'h0, r[12], r[15]}, {6'h0, addr26_oe_o, addr26_o});
      end
      $display("short delay test %0d done", i);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
